// file: src/wcs_pkg.sv
// Shared constants, encodings and carrier types of the washer cycle supervisor
package wcs_pkg;

	// ****************************************
	// Clock and time base
	// ****************************************
	localparam int CLK_HZ = 10_000_000;
	localparam int HALF_SEC_MS = 500;
	localparam int HALF_SEC_CYC = (CLK_HZ / 1000) * HALF_SEC_MS;
	localparam int HALF_PER_SEC = 2;
	localparam int SYNC_W = 6;

	// ****************************************
	// Supervision and pattern times in seconds
	// ****************************************
	localparam int HOLD_MAX_S = 7200;
	localparam int FILL_MAX_S = 1800;
	localparam int DRAIN_MAX_S = 840;
	localparam int SIS_WINDOW_S = 120;
	localparam int GENTLE_ON_S = 5;
	localparam int GENTLE_OFF_S = 10;
	localparam int SIS_ON_S = 2;
	localparam int SIS_OFF_S = 4;

	// Step lengths in seconds
	localparam int AGIT_WASH_S = 600;
	localparam int AGIT_RINSE_S = 240;
	localparam int SOAK_S = 480;
	localparam int SPIN_S = 240;

	localparam int CNT_W = 16;
	localparam int PAT_W = 8;

	// ****************************************
	// Encodings
	// ****************************************
	typedef enum logic [2:0] {
		PROG_OFF = 3'h0,
		PROG_SUPER = 3'h1,
		PROG_HEAVY = 3'h2,
		PROG_NORMAL = 3'h3,
		PROG_SPIN_ONLY = 3'h4,
		PROG_SOAK = 3'h5,
		PROG_DELICATE = 3'h6,
		PROG_PERM_PRESS = 3'h7
	} wcs_prog_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_FILL = 3'h1,
		ST_AGIT = 3'h3,
		ST_SOAK = 3'h2,
		ST_DRAIN = 3'h6,
		ST_SPIN = 3'h7
	} wcs_state_t;

	typedef enum logic [1:0] {
		PH_WASH = 2'h0,
		PH_RINSE = 2'h1,
		PH_FINAL = 2'h3
	} wcs_phase_t;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic wash;
		logic rinse;
		logic final_spin;
	} wcs_lamp_t;

	typedef struct packed {
		logic fill_valve;
		logic agitate;
		logic gentle_pulsed_agitation;
		logic drain_pump;
		logic spin;
	} wcs_load_t;

	typedef struct packed {
		logic running;
		logic held;
		logic fill_fault;
		logic drain_fault;
	} wcs_stat_t;

	localparam wcs_lamp_t LAMP_RST = '0;
	localparam wcs_load_t LOAD_RST = '0;
	localparam wcs_stat_t STAT_RST = '0;

	// Seconds to half-second ticks
	function automatic logic [CNT_W-1:0] sec2half(input int s);
		sec2half = CNT_W'(s * HALF_PER_SEC);
	endfunction : sec2half

	localparam logic [CNT_W-1:0] HOLD_MAX_H = sec2half(HOLD_MAX_S);
	localparam logic [CNT_W-1:0] FILL_MAX_H = sec2half(FILL_MAX_S);
	localparam logic [CNT_W-1:0] DRAIN_MAX_H = sec2half(DRAIN_MAX_S);
	localparam logic [CNT_W-1:0] SIS_WINDOW_H = sec2half(SIS_WINDOW_S);
	localparam logic [CNT_W-1:0] AGIT_WASH_H = sec2half(AGIT_WASH_S);
	localparam logic [CNT_W-1:0] AGIT_RINSE_H = sec2half(AGIT_RINSE_S);
	localparam logic [CNT_W-1:0] SOAK_H = sec2half(SOAK_S);
	localparam logic [CNT_W-1:0] SPIN_H = sec2half(SPIN_S);
	localparam logic [PAT_W-1:0] GENTLE_ON_H = PAT_W'(GENTLE_ON_S * HALF_PER_SEC);
	localparam logic [PAT_W-1:0] GENTLE_PER_H = PAT_W'((GENTLE_ON_S + GENTLE_OFF_S) * HALF_PER_SEC);
	localparam logic [PAT_W-1:0] SIS_ON_H = PAT_W'(SIS_ON_S * HALF_PER_SEC);
	localparam logic [PAT_W-1:0] SIS_PER_H = PAT_W'((SIS_ON_S + SIS_OFF_S) * HALF_PER_SEC);

endpackage : wcs_pkg

// file: src/wcs_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module wcs_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys_in, // System clock
	input wire logic reset_n_in, // Asynchronous reset, active low
	input wire logic [W-1:0] async_in, // Pin levels
	output logic [W-1:0] sync_out // Synchronised levels
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			meta_ff <= '0;
			sync_out <= '0;
		end else begin
			meta_ff <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule : wcs_sync

// file: src/wcs_tick_div.sv
// Divider that yields a one-cycle enable every DIV clock cycles
`timescale 1ns/100ps
module wcs_tick_div #(
	parameter int DIV = 5_000_000
) (
	input wire logic clk_sys_in, // System clock
	input wire logic reset_n_in, // Asynchronous reset, active low
	output logic tick_out // One-cycle pulse every DIV cycles
);
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt_ff;

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt_ff <= '0;
			tick_out <= 1'b0;
		end else begin
			tick_out <= (cnt_ff == LAST);
			cnt_ff <= (cnt_ff == LAST) ? '0 : cnt_ff + 1'b1;
		end
	end
endmodule : wcs_tick_div

// file: src/wcs_top.sv
// Washer cycle supervisor: program sequencing, hold, lamps and loads
`timescale 1ns/100ps
module wcs_top #(
	parameter int HALF_SEC_CYCLES = wcs_pkg::HALF_SEC_CYC
) (
	input wire logic clk_sys_in, // 10 MHz system clock
	input wire logic reset_n_in, // Power-on reset, active low
	input wire logic run_hold_btn_in, // Run/hold button, high while pressed
	input wire logic [2:0] cycle_sel_in, // Cycle selector position
	input wire logic level_full_in, // Water at the chosen level
	input wire logic level_low_in, // Water level switch reports low
	output wcs_pkg::wcs_lamp_t lamp_out, // Phase lamps
	output wcs_pkg::wcs_load_t load_out, // Valve, motor and pump drives
	output wcs_pkg::wcs_stat_t stat_out // Run, hold and fault status
);

	// ****************************************
	// Input synchronisation and time base
	// ****************************************
	logic [wcs_pkg::SYNC_W-1:0] pins_s;
	logic btn_s;
	logic full_s;
	logic low_s;
	wcs_pkg::wcs_prog_t sel_s;
	logic half_tick;

	wcs_sync #(
		.W(wcs_pkg::SYNC_W)
	) u_sync (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.async_in({run_hold_btn_in, cycle_sel_in, level_full_in, level_low_in}),
		.sync_out(pins_s)
	);

	assign btn_s = pins_s[5];
	assign sel_s = wcs_pkg::wcs_prog_t'(pins_s[4:2]);
	assign full_s = pins_s[1];
	assign low_s = pins_s[0];

	wcs_tick_div #(
		.DIV(HALF_SEC_CYCLES)
	) u_tick (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.tick_out(half_tick)
	);

	// ****************************************
	// Button edge, selector arming
	// ****************************************
	logic btn_d_ff;
	logic press;
	logic sel_off;
	logic armed_ff;

	assign press = btn_s & ~btn_d_ff;
	assign sel_off = (sel_s == wcs_pkg::PROG_OFF);

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			btn_d_ff <= 1'b0;
		end else begin
			btn_d_ff <= btn_s;
		end
	end

	wcs_pkg::wcs_state_t state_ff;
	wcs_pkg::wcs_state_t nxt_state;
	wcs_pkg::wcs_phase_t phase_ff;
	wcs_pkg::wcs_phase_t nxt_phase;
	wcs_pkg::wcs_prog_t prog_ff;
	logic start;
	logic active;

	assign active = (state_ff != wcs_pkg::ST_IDLE);
	assign start = ~active & press & armed_ff & ~sel_off;

	// A new program needs the selector to have passed through off
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			armed_ff <= 1'b0;
		end else if (sel_off) begin
			armed_ff <= 1'b1;
		end else if (start) begin
			armed_ff <= 1'b0;
		end
	end

	// ****************************************
	// Hold and its abandon timer
	// ****************************************
	logic held_ff;
	logic blink_ff;
	logic [wcs_pkg::CNT_W-1:0] hold_cnt_ff;
	logic hold_expired;
	logic abort;
	logic fill_late;
	logic drain_late;

	assign hold_expired = held_ff & half_tick & (hold_cnt_ff >= wcs_pkg::HOLD_MAX_H);
	assign abort = active & (sel_off | hold_expired | fill_late | drain_late);

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			held_ff <= 1'b0;
		end else if (abort | ~active) begin
			held_ff <= 1'b0;
		end else if (press) begin
			held_ff <= ~held_ff;
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			hold_cnt_ff <= '0;
			blink_ff <= 1'b0;
		end else if (!held_ff) begin
			hold_cnt_ff <= '0;
			blink_ff <= 1'b0;
		end else if (half_tick) begin
			hold_cnt_ff <= hold_cnt_ff + 1'b1;
			blink_ff <= ~blink_ff;
		end
	end

	// ****************************************
	// Step timers
	// ****************************************
	logic run_tick;
	logic step_new;
	logic [wcs_pkg::CNT_W-1:0] step_cnt_ff;
	logic [wcs_pkg::PAT_W-1:0] pat_cnt_ff;
	logic [wcs_pkg::PAT_W-1:0] pat_per;

	assign run_tick = half_tick & ~held_ff;
	assign step_new = (nxt_state != state_ff) | (nxt_phase != phase_ff);
	assign pat_per = (state_ff == wcs_pkg::ST_AGIT) ? wcs_pkg::GENTLE_PER_H : wcs_pkg::SIS_PER_H;
	assign fill_late = (state_ff == wcs_pkg::ST_FILL) & ~full_s
		& (step_cnt_ff >= wcs_pkg::FILL_MAX_H);
	assign drain_late = (state_ff == wcs_pkg::ST_DRAIN) & ~low_s
		& (step_cnt_ff >= wcs_pkg::DRAIN_MAX_H);

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			step_cnt_ff <= '0;
		end else if (step_new) begin
			step_cnt_ff <= '0;
		end else if (run_tick && step_cnt_ff != '1) begin
			step_cnt_ff <= step_cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pat_cnt_ff <= '0;
		end else if (step_new) begin
			pat_cnt_ff <= '0;
		end else if (run_tick) begin
			pat_cnt_ff <= (pat_cnt_ff >= pat_per - 1'b1) ? '0 : pat_cnt_ff + 1'b1;
		end
	end

	// ****************************************
	// Program sequencer
	// ****************************************
	logic [wcs_pkg::CNT_W-1:0] agit_len;

	assign agit_len = (phase_ff == wcs_pkg::PH_WASH) ? wcs_pkg::AGIT_WASH_H : wcs_pkg::AGIT_RINSE_H;

	always_comb begin
		nxt_state = state_ff;
		nxt_phase = phase_ff;
		if (abort) begin
			nxt_state = wcs_pkg::ST_IDLE;
			nxt_phase = wcs_pkg::PH_WASH;
		end else if (!held_ff) begin
			case (state_ff)
				wcs_pkg::ST_IDLE: begin
					if (start && sel_s == wcs_pkg::PROG_SPIN_ONLY) begin
						nxt_state = wcs_pkg::ST_DRAIN;
						nxt_phase = wcs_pkg::PH_RINSE;
					end else if (start) begin
						nxt_state = wcs_pkg::ST_FILL;
						nxt_phase = wcs_pkg::PH_WASH;
					end
				end
				wcs_pkg::ST_FILL: begin
					if (full_s) begin
						nxt_state = wcs_pkg::ST_AGIT;
					end
				end
				wcs_pkg::ST_AGIT: begin
					if (step_cnt_ff >= agit_len) begin
						if (prog_ff == wcs_pkg::PROG_SOAK && phase_ff == wcs_pkg::PH_WASH) begin
							nxt_state = wcs_pkg::ST_SOAK;
						end else begin
							nxt_state = wcs_pkg::ST_DRAIN;
						end
					end
				end
				wcs_pkg::ST_SOAK: begin
					if (step_cnt_ff >= wcs_pkg::SOAK_H) begin
						nxt_state = wcs_pkg::ST_DRAIN;
					end
				end
				wcs_pkg::ST_DRAIN: begin
					if (low_s) begin
						nxt_state = wcs_pkg::ST_SPIN;
						if (phase_ff == wcs_pkg::PH_RINSE) begin
							nxt_phase = wcs_pkg::PH_FINAL;
						end
					end
				end
				wcs_pkg::ST_SPIN: begin
					if (step_cnt_ff >= wcs_pkg::SPIN_H) begin
						if (phase_ff == wcs_pkg::PH_WASH) begin
							nxt_state = wcs_pkg::ST_FILL;
							nxt_phase = wcs_pkg::PH_RINSE;
						end else begin
							nxt_state = wcs_pkg::ST_IDLE;
							nxt_phase = wcs_pkg::PH_WASH;
						end
					end
				end
				default: begin
					nxt_state = wcs_pkg::ST_IDLE;
					nxt_phase = wcs_pkg::PH_WASH;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_ff <= wcs_pkg::ST_IDLE;
			phase_ff <= wcs_pkg::PH_WASH;
		end else begin
			state_ff <= nxt_state;
			phase_ff <= nxt_phase;
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			prog_ff <= wcs_pkg::PROG_OFF;
		end else if (start) begin
			prog_ff <= sel_s;
		end
	end

	// ****************************************
	// Lamp and load drive
	// ****************************************
	logic gentle_prog;
	logic sis_on;
	logic pat_on;
	wcs_pkg::wcs_lamp_t nxt_lamp;
	wcs_pkg::wcs_load_t nxt_load;
	wcs_pkg::wcs_stat_t nxt_stat;

	assign gentle_prog = (prog_ff == wcs_pkg::PROG_DELICATE) | (prog_ff == wcs_pkg::PROG_PERM_PRESS);
	assign sis_on = gentle_prog | (step_cnt_ff < wcs_pkg::SIS_WINDOW_H);
	assign pat_on = (state_ff == wcs_pkg::ST_AGIT) ? (pat_cnt_ff < wcs_pkg::GENTLE_ON_H)
		: (pat_cnt_ff < wcs_pkg::SIS_ON_H);

	always_comb begin
		nxt_lamp = wcs_pkg::LAMP_RST;
		if (active && !abort) begin
			nxt_lamp.wash = (phase_ff == wcs_pkg::PH_WASH);
			nxt_lamp.rinse = (phase_ff == wcs_pkg::PH_RINSE);
			nxt_lamp.final_spin = (phase_ff == wcs_pkg::PH_FINAL);
			if (held_ff && !blink_ff) begin
				nxt_lamp = wcs_pkg::LAMP_RST;
			end
		end
	end

	always_comb begin
		nxt_load = wcs_pkg::LOAD_RST;
		if (active && !abort && !held_ff) begin
			case (state_ff)
				wcs_pkg::ST_FILL: nxt_load.fill_valve = 1'b1;
				wcs_pkg::ST_AGIT: begin
					if (gentle_prog) begin
						nxt_load.gentle_pulsed_agitation = pat_on;
					end else begin
						nxt_load.agitate = 1'b1;
					end
				end
				wcs_pkg::ST_DRAIN: nxt_load.drain_pump = 1'b1;
				wcs_pkg::ST_SPIN: begin
					nxt_load.drain_pump = 1'b1;
					nxt_load.spin = sis_on ? pat_on : 1'b1;
				end
				default: nxt_load = wcs_pkg::LOAD_RST;
			endcase
		end
	end

	always_comb begin
		nxt_stat = stat_out;
		nxt_stat.running = active & ~abort;
		nxt_stat.held = held_ff & ~abort;
		if (start) begin
			nxt_stat.fill_fault = 1'b0;
			nxt_stat.drain_fault = 1'b0;
		end else begin
			nxt_stat.fill_fault = stat_out.fill_fault | fill_late;
			nxt_stat.drain_fault = stat_out.drain_fault | drain_late;
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			lamp_out <= wcs_pkg::LAMP_RST;
			load_out <= wcs_pkg::LOAD_RST;
			stat_out <= wcs_pkg::STAT_RST;
		end else begin
			lamp_out <= nxt_lamp;
			load_out <= nxt_load;
			stat_out <= nxt_stat;
		end
	end

endmodule : wcs_top

// file: verif/wcs_top_assertions.sv
// Port checker for the washer cycle supervisor
`timescale 1ns/100ps
module wcs_top_assertions #(
	parameter int HALF_SEC_CYCLES = 2
) (
	input wire logic clk_sys_in, // Clock
	input wire logic reset_n_in, // Reset, active low
	input wire logic run_hold_btn_in, // Button
	input wire logic [2:0] cycle_sel_in, // Selector
	input wire logic level_full_in, // Level full
	input wire logic level_low_in, // Level low
	input wcs_pkg::wcs_lamp_t lamp_out, // Lamps
	input wcs_pkg::wcs_load_t load_out, // Loads
	input wcs_pkg::wcs_stat_t stat_out // Status
);
	localparam int FILL_HI = 3600 * HALF_SEC_CYCLES + 2 * HALF_SEC_CYCLES + 4;
	localparam int FILL_LO = 3600 * HALF_SEC_CYCLES - 2 * HALF_SEC_CYCLES - 4;
	localparam int HOLD_HI = 14400 * HALF_SEC_CYCLES + 2 * HALF_SEC_CYCLES + 4;
	int fill_cnt_ff;
	int hold_cnt_ff;

	// ****************************************
	// Fill and hold timers seen from the ports
	// ****************************************
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			fill_cnt_ff <= 0;
		end else if (load_out.fill_valve) begin
			fill_cnt_ff <= fill_cnt_ff + 1;
		end else if (!stat_out.held) begin
			fill_cnt_ff <= 0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			hold_cnt_ff <= 0;
		end else begin
			hold_cnt_ff <= stat_out.held ? hold_cnt_ff + 1 : 0;
		end
	end

	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!reset_n_in);

	sequence idle_s;
		!stat_out.running && !stat_out.held;
	endsequence
	sequence run_press_s;
		stat_out.running && !stat_out.held && $rose(run_hold_btn_in) ##1 run_hold_btn_in;
	endsequence

	off_dark_a: assert property (idle_s |-> lamp_out == '0)
		else $error("lamps lit while off");
	idle_loads_a: assert property (idle_s |-> load_out == '0)
		else $error("load driven while idle");
	hold_loads_a: assert property (stat_out.held |-> load_out == '0)
		else $error("load driven while held");
	press_hold_a: assert property (run_press_s |-> ##[2:5] stat_out.held)
		else $error("press did not hold");
	hold_blink_a: assert property (stat_out.held [*4] |-> lamp_out != $past(lamp_out, 2))
		else $error("lamps not blinking while held");
	resume_steady_a: assert property ($fell(stat_out.held) && stat_out.running |=>
		($stable(lamp_out) && lamp_out != '0) [*3])
		else $error("lamps not steady after resume");
	fill_abort_a: assert property ($rose(stat_out.fill_fault) |-> $past(load_out.fill_valve)
		&& $past(fill_cnt_ff) > FILL_LO ##[0:1] (lamp_out == '0 && load_out == '0))
		else $error("fill abort wrong");
	drain_abort_a: assert property ($rose(stat_out.drain_fault) |-> $past(load_out.drain_pump)
		##[0:1] (lamp_out == '0 && load_out == '0 && !stat_out.running))
		else $error("drain abort wrong");
	sel_off_a: assert property ((cycle_sel_in == 3'h0) [*6] |-> idle_s)
		else $error("selector off did not stop");
	fill_time_a: assert property (load_out.fill_valve |-> fill_cnt_ff < FILL_HI)
		else $error("fill ran too long");
	hold_time_a: assert property (stat_out.held |-> hold_cnt_ff < HOLD_HI)
		else $error("hold ran too long");

endmodule : wcs_top_assertions

bind wcs_top wcs_top_assertions #(.HALF_SEC_CYCLES(HALF_SEC_CYCLES)) u_chk (.clk_sys_in,
	.reset_n_in, .run_hold_btn_in, .cycle_sel_in, .level_full_in, .level_low_in, .lamp_out,
	.load_out, .stat_out);

// file: verif/wcs_water_model.sv
// Tub and water level switch model
`timescale 1ns/100ps
module wcs_water_model (
	input wire logic clk_sys_in, // Clock
	input wire logic fill_in, // Fill valve drive
	input wire logic drain_in, // Drain pump drive
	input wire logic fill_ok_in, // Supply delivers water
	input wire logic drain_ok_in, // Pump removes water
	output logic level_full_out, // Tub at chosen level
	output logic level_low_out // Tub empty
);
	int water_ff = 0;

	// Water moves one unit a cycle, just after the edge
	always @(posedge clk_sys_in) begin
		#1;
		if (fill_in && fill_ok_in && water_ff < 20) begin
			water_ff = water_ff + 1;
		end else if (drain_in && drain_ok_in && water_ff > 0) begin
			water_ff = water_ff - 1;
		end
	end

	assign level_full_out = (water_ff >= 20);
	assign level_low_out = (water_ff == 0);

endmodule : wcs_water_model

// file: verif/wcs_top_test.sv
// Self-checking bench for the washer cycle supervisor
`timescale 1ns/100ps
module wcs_top_test;
	localparam int HSC = 2;
	logic clk_sys_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic btn = 1'b0;
	logic [2:0] sel = 3'h0;
	logic fill_ok = 1'b1;
	logic drain_ok = 1'b1;
	logic full;
	logic low;
	wcs_pkg::wcs_lamp_t lamp;
	wcs_pkg::wcs_load_t load;
	wcs_pkg::wcs_stat_t stat;
	int fail_count = 0;
	int n_tests = 0;
	int cyc = 0;
	int i;
	int rises;
	logic [2:0] seen;
	logic spin_d;

	wcs_top #(.HALF_SEC_CYCLES(HSC)) uut (.clk_sys_in, .reset_n_in, .run_hold_btn_in(btn),
		.cycle_sel_in(sel), .level_full_in(full), .level_low_in(low), .lamp_out(lamp),
		.load_out(load), .stat_out(stat));
	wcs_water_model u_water (.clk_sys_in, .fill_in(load.fill_valve), .drain_in(load.drain_pump),
		.fill_ok_in(fill_ok), .drain_ok_in(drain_ok), .level_full_out(full), .level_low_out(low));

	// ****************************************
	// Clock, timeout and tasks
	// ****************************************
	initial begin
		forever #50 clk_sys_in = ~clk_sys_in;
	end

	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (cyc == 70000) begin
			fail_count++;
			finish_test();
		end
	end

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask : tick

	task automatic press();
		btn = 1'b1;
		tick(3);
		btn = 1'b0;
		tick(6);
	endtask : press

	task automatic start(input logic [2:0] prog);
		sel = 3'h0;
		tick(5);
		sel = prog;
		tick(3);
		press();
	endtask : start

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		tick(12);
		reset_n_in = 1'b1;
		tick(20);
		chk({stat, lamp, load}, 12'h000);
		for (int p = 1; p < 8; p++) begin
			start(p[2:0]);
			chk(stat, 12'h008);
			chk(lamp.wash, 12'(p != 4));
			sel = 3'h0;
			tick(6);
			chk({lamp, load}, 12'h000);
		end
		start(3'h3);
		for (i = 0; i < 200 && !load.agitate; i++) tick(1);
		press();
		chk({stat.held, load}, 12'h020);
		seen = lamp;
		tick(HSC);
		chk(lamp ^ seen, 12'h004);
		press();
		chk({stat.held, lamp, load.agitate}, 12'h009);
		seen = 3'h0;
		rises = 0;
		for (i = 0; i < 20000 && stat.running; i++) begin
			seen = seen | lamp;
			spin_d = load.spin;
			tick(1);
			rises = rises + int'(load.spin && !spin_d);
		end
		chk({seen, stat}, 12'h070);
		chk(12'(rises > 10), 12'h001);
		fill_ok = 1'b0;
		start(3'h3);
		for (i = 0; i < 3700 * HSC && !stat.fill_fault; i++) tick(1);
		tick(2);
		chk({stat, lamp, load}, 12'h200);
		fill_ok = 1'b1;
		drain_ok = 1'b0;
		start(3'h3);
		for (i = 0; i < 3000 * HSC && !stat.drain_fault; i++) tick(1);
		tick(2);
		chk({stat, lamp, load}, 12'h100);
		start(3'h3);
		tick(40);
		press();
		tick(14400 * HSC - 20);
		chk(stat, 12'h00c);
		tick(40);
		chk({stat, lamp, load}, 12'h000);
		start(3'h5);
		for (i = 0; i < 200 && !load.agitate; i++) tick(1);
		for (i = 0; i < 1300 * HSC && load.agitate; i++) tick(1);
		tick(8);
		chk({stat, lamp, load}, 12'h880);
		press();
		seen = lamp;
		tick(HSC);
		chk(lamp ^ seen, 12'h004);
		start(3'h6);
		for (i = 0; i < 200 && !load.gentle_pulsed_agitation; i++) tick(1);
		for (i = 0; i < 200 && load.gentle_pulsed_agitation; i++) tick(1);
		for (i = 0; i < 200 && !load.gentle_pulsed_agitation; i++) tick(1);
		chk(12'(i), 12'(wcs_pkg::GENTLE_OFF_S * wcs_pkg::HALF_PER_SEC * HSC));
		for (i = 0; i < 200 && load.gentle_pulsed_agitation; i++) tick(1);
		chk(12'(i), 12'(wcs_pkg::GENTLE_ON_S * wcs_pkg::HALF_PER_SEC * HSC));
		sel = 3'h0;
		tick(8);
		finish_test();
	end

endmodule : wcs_top_test
